// ### rtl/can_prot_pkg.sv
// shared constants and types for the transceiver protection logic
package can_prot_pkg;

    ////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int CLK_HZ = 25_000_000;
    // dominant timeout period in microseconds, plain default
    localparam int DOM_TIMEOUT_TIME_US = 1000;
    localparam int DOM_TIMEOUT_CYCLES = DOM_TIMEOUT_TIME_US * (CLK_HZ / 1_000_000);
    // thermal recovery interval in milliseconds
    localparam int THERMAL_TIME_MS = 300;
    localparam int THERMAL_CYCLES = THERMAL_TIME_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 24;

    ////////////////////////////////////////////////////////////////////////
    // device modes
    typedef enum logic [1:0]
    {
        MODE_SLEEP,
        MODE_STANDBY,
        MODE_NORMAL,
        MODE_THERMAL_PROT
    } dev_mode_t;

    localparam dev_mode_t MODE_RESET = MODE_STANDBY;

    // host mode-change write: one-cycle valid with the requested mode
    typedef struct packed
    {
        logic valid;
        dev_mode_t mode;
    } mode_req_t;

    // thermal status carried out of the top as one group
    typedef struct packed
    {
        logic regulator_on;
        logic supply_on;
        logic flag;
        logic irq;
    } thermal_stat_t;

    localparam thermal_stat_t THERMAL_STAT_RESET = '{regulator_on: 1'b1, supply_on: 1'b1, flag: 1'b0, irq: 1'b0};

endpackage

// ### rtl/interval_timer.sv
// one-shot down counter giving a single expiry pulse
`timescale 1ns/1ps
`default_nettype none

module interval_timer
    import can_prot_pkg::*;
#(
    parameter int CYCLES = THERMAL_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic start,
    input wire logic abort,
    // status
    output logic running,
    output logic expired
);

    logic [CNT_W-1:0] count_q;

    ////////////////////////////////////////////////////////////////////////
    // start reloads even while running, so a restart stretches the interval
    always_ff @(posedge clk)
    begin
        if (!rst_n || abort)
        begin
            count_q <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end
        else if (start)
        begin
            count_q <= CNT_W'(CYCLES - 1);
            running <= 1'b1;
            expired <= 1'b0;
        end
        else if (running && count_q == '0)
        begin
            running <= 1'b0;
            expired <= 1'b1;
        end
        else
        begin
            count_q <= running ? count_q - 1'b1 : count_q;
            expired <= 1'b0;
        end
    end

endmodule // interval_timer

`default_nettype wire

// ### rtl/dom_timeout_monitor.sv
// dominant timeout supervisor on the selected transmit line, internal or test pin
`timescale 1ns/1ps
`default_nettype none

module dom_timeout_monitor
    import can_prot_pkg::*;
#(
    parameter int CYCLES = DOM_TIMEOUT_CYCLES
)
(
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // transmit level, low is dominant
    input wire logic txd,
    // driver block while timed out
    output logic timeout
);

    logic txd_q;
    logic armed_q;
    logic [CNT_W-1:0] count_q;
    logic fall;

    assign fall = txd_q && !txd;

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            txd_q <= 1'b1;
            armed_q <= 1'b0;
            count_q <= '0;
            timeout <= 1'b0;
        end
        else
        begin
            txd_q <= txd;
            if (txd)
            begin
                // recessive level clears the condition at once
                armed_q <= 1'b0;
                count_q <= '0;
                timeout <= 1'b0;
            end
            else if (fall)
            begin
                armed_q <= 1'b1;
                count_q <= '0;
            end
            else if (armed_q)
            begin
                if (count_q == CNT_W'(CYCLES - 2))
                begin
                    armed_q <= 1'b0;
                    timeout <= 1'b1;
                end
                count_q <= count_q + 1'b1;
            end
        end
    end

endmodule // dom_timeout_monitor

`default_nettype wire

// ### rtl/can_transceiver_protection.sv
// transceiver driver gating, dominant timeout and thermal shutdown sequencing
`timescale 1ns/1ps
`default_nettype none

module can_transceiver_protection
    import can_prot_pkg::*;
#(
    parameter int DOM_TIMEOUT_CNT = DOM_TIMEOUT_CYCLES,
    parameter int THERMAL_CNT = THERMAL_CYCLES
)
(
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // protocol controller side
    input wire logic TXD_INT,
    output logic RXD_INT,
    output logic CONTROLLER_INIT_REQUEST,
    output logic PENDING_TX_HALT,
    // host mode control
    input wire mode_req_t MODE_REQ,
    output dev_mode_t DEVICE_MODE,
    // test mode pins
    input wire logic TEST_MODE,
    input wire logic FIRST_GENERAL_PIN,
    output logic SECOND_OUTPUT_PIN,
    // analog transceiver
    input wire logic BUS_RX_DOMINANT,
    output logic BUS_DRIVE_DOMINANT,
    output logic BUS_BIAS_RECESSIVE,
    output logic DOMINANT_TIMEOUT,
    // thermal and supply monitors
    input wire logic THERMAL_FAULT,
    input wire logic IO_UNDERVOLTAGE,
    input wire logic THERMAL_FLAG_CLR,
    output thermal_stat_t THERMAL_STAT
);

    ////////////////////////////////////////////////////////////////////////
    // internal signals

    dev_mode_t mode_q;
    dev_mode_t mode_d;
    logic fault_q;
    logic fault_rise;
    logic txd_eff;
    logic dom_block;
    logic timer_start;
    logic timer_expired;
    logic timer_running;
    logic init_req_d;
    logic drive_d;
    logic bias_d;

    // decoding used by the regulator and the supply status alike
    function automatic logic is_powered(input dev_mode_t m);
        is_powered = (m == MODE_NORMAL) || (m == MODE_STANDBY);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // transmit source selection

    // internal paths never reach pins outside test mode
    always_comb
    begin
        if (TEST_MODE)
        begin
            txd_eff = FIRST_GENERAL_PIN;
        end
        else
        begin
            txd_eff = TXD_INT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dominant timeout supervisor

    // interval fixed by parameter, sized in core clocks
    dom_timeout_monitor #(
        .CYCLES(DOM_TIMEOUT_CNT)
    ) u_dom_timeout (
        .clk(CLK),
        .rst_n(RST_N),
        .txd(txd_eff),
        .timeout(dom_block)
    );

    // the timeout period must exceed eleven bit times at the slowest rate used

    ////////////////////////////////////////////////////////////////////////
    // thermal recovery timer

    assign fault_rise = THERMAL_FAULT && !fault_q;

    interval_timer #(
        .CYCLES(THERMAL_CNT)
    ) u_thermal_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .start(timer_start),
        .abort(mode_q != MODE_THERMAL_PROT && mode_d != MODE_THERMAL_PROT),
        .running(timer_running),
        .expired(timer_expired)
    );

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            fault_q <= 1'b0;
        end
        else
        begin
            fault_q <= THERMAL_FAULT;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode sequencing

    always_comb
    begin
        mode_d = mode_q;
        timer_start = 1'b0;
        case (mode_q)
            MODE_THERMAL_PROT:
            begin
                if (MODE_REQ.valid && MODE_REQ.mode == MODE_SLEEP)
                begin
                    mode_d = MODE_SLEEP;
                end
                else if (THERMAL_FAULT && IO_UNDERVOLTAGE)
                begin
                    mode_d = MODE_SLEEP;
                end
                else if (timer_expired && !THERMAL_FAULT)
                begin
                    mode_d = MODE_STANDBY;
                end
                else if (timer_expired || (!timer_running && !timer_start))
                begin
                    // fault still present: stay protected and check again later
                    timer_start = 1'b1;
                end
            end
            MODE_NORMAL, MODE_STANDBY, MODE_SLEEP:
            begin
                if (fault_rise && IO_UNDERVOLTAGE)
                begin
                    mode_d = MODE_SLEEP;
                end
                else if (fault_rise && mode_q != MODE_SLEEP)
                begin
                    mode_d = MODE_THERMAL_PROT;
                    timer_start = 1'b1;
                end
                else if (MODE_REQ.valid && MODE_REQ.mode != MODE_THERMAL_PROT)
                begin
                    mode_d = MODE_REQ.mode;
                end
            end
            default:
            begin
                mode_d = MODE_RESET;
            end
        endcase
    end

    // host writes are decoded in every mode, but thermal protection takes only a sleep write
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            mode_q <= MODE_RESET;
            DEVICE_MODE <= MODE_RESET;
        end
        else
        begin
            mode_q <= mode_d;
            DEVICE_MODE <= mode_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // controller init request and pending traffic halt

    always_comb
    begin
        init_req_d = CONTROLLER_INIT_REQUEST;
        if (mode_d == MODE_NORMAL)
        begin
            init_req_d = 1'b0;
        end
        else if (mode_q == MODE_NORMAL && mode_d != MODE_NORMAL && THERMAL_FAULT)
        begin
            init_req_d = 1'b1;
        end
    end

    // halt follows the request so pending frames resume on its release
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            CONTROLLER_INIT_REQUEST <= 1'b0;
            PENDING_TX_HALT <= 1'b0;
        end
        else
        begin
            CONTROLLER_INIT_REQUEST <= init_req_d;
            PENDING_TX_HALT <= init_req_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus driver

    always_comb
    begin
        drive_d = 1'b0;
        bias_d = 1'b0;
        if (mode_d == MODE_NORMAL)
        begin
            bias_d = 1'b1;
            // timeout only blocks the driver, never the receiver
            drive_d = !txd_eff && !dom_block;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            BUS_DRIVE_DOMINANT <= 1'b0;
            BUS_BIAS_RECESSIVE <= 1'b0;
            DOMINANT_TIMEOUT <= 1'b0;
        end
        else
        begin
            BUS_DRIVE_DOMINANT <= drive_d;
            BUS_BIAS_RECESSIVE <= bias_d;
            DOMINANT_TIMEOUT <= dom_block;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receive path

    // receiver stays live regardless of the driver block
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            RXD_INT <= 1'b1;
            SECOND_OUTPUT_PIN <= 1'b0;
        end
        else
        begin
            RXD_INT <= !BUS_RX_DOMINANT;
            SECOND_OUTPUT_PIN <= TEST_MODE ? !BUS_RX_DOMINANT : 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // thermal status, flag and interrupt

    // set wins over a clear arriving in the same cycle
    always_ff @(posedge CLK)
    begin
        if (!RST_N)
        begin
            THERMAL_STAT <= THERMAL_STAT_RESET;
        end
        else
        begin
            THERMAL_STAT.regulator_on <= is_powered(mode_d);
            THERMAL_STAT.supply_on <= is_powered(mode_d);
            THERMAL_STAT.irq <= fault_rise;
            if (fault_rise)
            begin
                THERMAL_STAT.flag <= 1'b1;
            end
            else if (THERMAL_FLAG_CLR)
            begin
                THERMAL_STAT.flag <= 1'b0;
            end
        end
    end

endmodule // can_transceiver_protection

`default_nettype wire

// ### testbench/can_prot_chk.sv
// concurrent checks on the protection block ports
`timescale 1ns/1ps
`default_nettype none

module can_prot_chk
    import can_prot_pkg::*;
(
    // watched ports
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic TXD_INT,
    input wire logic RXD_INT,
    input wire logic TEST_MODE,
    input wire logic SECOND_OUTPUT_PIN,
    input wire logic BUS_RX_DOMINANT,
    input wire logic BUS_DRIVE_DOMINANT,
    input wire logic BUS_BIAS_RECESSIVE,
    input wire logic DOMINANT_TIMEOUT,
    input wire logic THERMAL_FAULT,
    input wire logic IO_UNDERVOLTAGE,
    input wire mode_req_t MODE_REQ,
    input wire dev_mode_t DEVICE_MODE,
    input wire thermal_stat_t THERMAL_STAT
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    ////////////////////////////////////////////////////////////////////////
    a_drive_normal_only: assert property (BUS_DRIVE_DOMINANT |-> DEVICE_MODE == MODE_NORMAL)
        else $error("bus driven outside normal mode");
    a_bias_tracks_mode: assert property (BUS_BIAS_RECESSIVE == (DEVICE_MODE == MODE_NORMAL))
        else $error("recessive bias does not match mode");
    a_blocked_no_drive: assert property (DOMINANT_TIMEOUT |-> !BUS_DRIVE_DOMINANT)
        else $error("driver active while timed out");
    a_release_clears: assert property (DOMINANT_TIMEOUT && TXD_INT && !TEST_MODE |-> ##[1:2] !DOMINANT_TIMEOUT)
        else $error("timeout not cleared by recessive level");
    // past reset guard: reset forces the receive output high
    a_rx_mirrors_bus: assert property ($past(RST_N) |-> RXD_INT == !$past(BUS_RX_DOMINANT))
        else $error("receive output does not follow bus");
    a_pin_route_off: assert property ($past(!TEST_MODE) |-> !SECOND_OUTPUT_PIN)
        else $error("receive reaches pin outside test mode");
    a_thermal_entry: assert property ($rose(THERMAL_FAULT) && !IO_UNDERVOLTAGE && DEVICE_MODE != MODE_SLEEP
        |=> DEVICE_MODE == MODE_THERMAL_PROT && THERMAL_STAT == 4'h3)
        else $error("thermal entry wrong");
    a_irq_one_cycle: assert property (THERMAL_STAT.irq |=> !THERMAL_STAT.irq)
        else $error("interrupt longer than one cycle");
    a_uv_to_sleep: assert property ($rose(THERMAL_FAULT) && IO_UNDERVOLTAGE |=> DEVICE_MODE == MODE_SLEEP)
        else $error("fault in undervoltage did not sleep");
    a_prot_sleep_ok: assert property (DEVICE_MODE == MODE_THERMAL_PROT && MODE_REQ.valid && MODE_REQ.mode == MODE_SLEEP
        && !$rose(THERMAL_FAULT) |=> DEVICE_MODE == MODE_SLEEP)
        else $error("sleep write refused in protection");

    ////////////////////////////////////////////////////////////////////////
    c_timeout: cover property ($rose(DOMINANT_TIMEOUT));
    c_prot: cover property (DEVICE_MODE == MODE_THERMAL_PROT);
    c_test_pin: cover property (TEST_MODE && SECOND_OUTPUT_PIN);
endmodule // can_prot_chk

`default_nettype wire

// ### testbench/can_bus_model.sv
// bus side: wired dominant of local driver and other nodes
`timescale 1ns/1ps
`default_nettype none

module can_bus_model
(
    // local driver and other nodes
    input wire logic drive_dominant,
    input wire logic other_dominant,
    // comparator view
    output logic rx_dominant
);
    // any node dominant wins, no node leaves the bus recessive
    assign rx_dominant = drive_dominant | other_dominant;
endmodule // can_bus_model

`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the transceiver protection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end

module tb_top;
    import can_prot_pkg::*;
    localparam int TO_CNT = 20;
    localparam int THM = 30;
    logic CLK, RST_N, TXD_INT, TEST_MODE, FIRST_GENERAL_PIN, THERMAL_FAULT, IO_UNDERVOLTAGE, THERMAL_FLAG_CLR;
    logic RXD_INT, CONTROLLER_INIT_REQUEST, PENDING_TX_HALT, SECOND_OUTPUT_PIN;
    logic BUS_RX_DOMINANT, BUS_DRIVE_DOMINANT, BUS_BIAS_RECESSIVE, DOMINANT_TIMEOUT, other_q;
    mode_req_t MODE_REQ;
    dev_mode_t DEVICE_MODE;
    thermal_stat_t THERMAL_STAT;
    int err_count = 0;
    int check_count = 0;

    can_transceiver_protection #(.DOM_TIMEOUT_CNT(TO_CNT), .THERMAL_CNT(THM)) dut_u (.CLK, .RST_N, .TXD_INT, .RXD_INT,
        .CONTROLLER_INIT_REQUEST, .PENDING_TX_HALT, .MODE_REQ, .DEVICE_MODE, .TEST_MODE, .FIRST_GENERAL_PIN,
        .SECOND_OUTPUT_PIN, .BUS_RX_DOMINANT, .BUS_DRIVE_DOMINANT, .BUS_BIAS_RECESSIVE, .DOMINANT_TIMEOUT,
        .THERMAL_FAULT, .IO_UNDERVOLTAGE, .THERMAL_FLAG_CLR, .THERMAL_STAT);
    can_bus_model bus_u (.drive_dominant(BUS_DRIVE_DOMINANT), .other_dominant(other_q), .rx_dominant(BUS_RX_DOMINANT));

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        CLK = 1'b0;
        forever #20 CLK = ~CLK;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask

    task automatic set_mode(input dev_mode_t m);
        MODE_REQ = '{1'b1, m};
        cyc(1);
        MODE_REQ = '0;
    endtask

    task automatic close_out;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_drive;
        TXD_INT = 1'b0;
        cyc(2);
        `CHK(BUS_DRIVE_DOMINANT, 1'b0)
        TXD_INT = 1'b1;
        set_mode(MODE_NORMAL);
        `CHK(BUS_BIAS_RECESSIVE, 1'b1)
        TXD_INT = 1'b0;
        cyc(2);
        `CHK(BUS_DRIVE_DOMINANT, 1'b1)
        `CHK(RXD_INT, 1'b0)
        TXD_INT = 1'b1;
        cyc(2);
        `CHK(BUS_DRIVE_DOMINANT, 1'b0)
        $display("drive test done");
    endtask

    task automatic t_timeout;
        // stretches shorter than the timeout stand for a legal bit rate
        TXD_INT = 1'b0;
        cyc(TO_CNT - 4);
        TXD_INT = 1'b1;
        cyc(1);
        TXD_INT = 1'b0;
        cyc(TO_CNT - 4);
        `CHK(DOMINANT_TIMEOUT, 1'b0)
        cyc(8);
        `CHK(DOMINANT_TIMEOUT, 1'b1)
        `CHK(BUS_DRIVE_DOMINANT, 1'b0)
        other_q = 1'b1;
        cyc(2);
        `CHK(RXD_INT, 1'b0)
        other_q = 1'b0;
        TXD_INT = 1'b1;
        cyc(3);
        `CHK(DOMINANT_TIMEOUT, 1'b0)
        TXD_INT = 1'b0;
        cyc(2);
        `CHK(BUS_DRIVE_DOMINANT, 1'b1)
        TXD_INT = 1'b1;
        cyc(2);
        $display("timeout test done");
    endtask

    task automatic t_test_pins;
        TEST_MODE = 1'b1;
        cyc(3);
        `CHK(BUS_DRIVE_DOMINANT, 1'b1)
        `CHK(SECOND_OUTPUT_PIN, 1'b0)
        // dominant held on the test pin must time out like the internal line
        cyc(TO_CNT + 2);
        `CHK(DOMINANT_TIMEOUT, 1'b1)
        `CHK(BUS_DRIVE_DOMINANT, 1'b0)
        `CHK(SECOND_OUTPUT_PIN, 1'b1)
        FIRST_GENERAL_PIN = 1'b1;
        cyc(3);
        `CHK(SECOND_OUTPUT_PIN, 1'b1)
        FIRST_GENERAL_PIN = 1'b0;
        TEST_MODE = 1'b0;
        cyc(3);
        `CHK(SECOND_OUTPUT_PIN, 1'b0)
        `CHK(BUS_DRIVE_DOMINANT, 1'b0)
        $display("test pin test done");
    endtask

    task automatic t_thermal;
        THERMAL_FAULT = 1'b1;
        cyc(1);
        `CHK(DEVICE_MODE, MODE_THERMAL_PROT)
        `CHK(THERMAL_STAT, 4'h3)
        `CHK({CONTROLLER_INIT_REQUEST, PENDING_TX_HALT}, 2'h3)
        set_mode(MODE_NORMAL);
        cyc(1);
        set_mode(MODE_STANDBY);
        `CHK(DEVICE_MODE, MODE_THERMAL_PROT)
        `CHK(THERMAL_STAT.irq, 1'b0)
        // flag clear still acts while protected
        THERMAL_FLAG_CLR = 1'b1;
        cyc(1);
        THERMAL_FLAG_CLR = 1'b0;
        `CHK(THERMAL_STAT.flag, 1'b0)
        // timer restarts while the fault persists, so the wait is longer
        cyc(THM + 4);
        `CHK(DEVICE_MODE, MODE_THERMAL_PROT)
        THERMAL_FAULT = 1'b0;
        cyc(THM + 4);
        `CHK(DEVICE_MODE, MODE_STANDBY)
        `CHK(THERMAL_STAT, 4'hc)
        `CHK(CONTROLLER_INIT_REQUEST, 1'b1)
        THERMAL_FLAG_CLR = 1'b1;
        cyc(1);
        THERMAL_FLAG_CLR = 1'b0;
        set_mode(MODE_NORMAL);
        `CHK(CONTROLLER_INIT_REQUEST, 1'b0)
        `CHK(THERMAL_STAT.flag, 1'b0)
        // clear in the same cycle as the fault edge loses
        THERMAL_FAULT = 1'b1;
        THERMAL_FLAG_CLR = 1'b1;
        cyc(1);
        THERMAL_FLAG_CLR = 1'b0;
        `CHK(THERMAL_STAT.flag, 1'b1)
        set_mode(MODE_SLEEP);
        `CHK(DEVICE_MODE, MODE_SLEEP)
        THERMAL_FAULT = 1'b0;
        cyc(1);
        set_mode(MODE_STANDBY);
        IO_UNDERVOLTAGE = 1'b1;
        THERMAL_FAULT = 1'b1;
        cyc(1);
        `CHK(DEVICE_MODE, MODE_SLEEP)
        THERMAL_FAULT = 1'b0;
        IO_UNDERVOLTAGE = 1'b0;
        // undervoltage arriving while already protected
        cyc(1);
        set_mode(MODE_STANDBY);
        THERMAL_FAULT = 1'b1;
        cyc(1);
        `CHK(DEVICE_MODE, MODE_THERMAL_PROT)
        IO_UNDERVOLTAGE = 1'b1;
        cyc(1);
        `CHK(DEVICE_MODE, MODE_SLEEP)
        THERMAL_FAULT = 1'b0;
        IO_UNDERVOLTAGE = 1'b0;
        $display("thermal test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        {RST_N, TEST_MODE, FIRST_GENERAL_PIN, THERMAL_FAULT, IO_UNDERVOLTAGE, THERMAL_FLAG_CLR, other_q} = '0;
        TXD_INT = 1'b1;
        MODE_REQ = '0;
        cyc(4);
        RST_N = 1'b1;
        cyc(1);
        `CHK(DEVICE_MODE, MODE_RESET)
        `CHK(THERMAL_STAT, THERMAL_STAT_RESET)
        `CHK(RXD_INT, 1'b1)
        t_drive();
        t_timeout();
        t_test_pins();
        t_thermal();
        close_out();
    end

    // the whole run needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge CLK);
        err_count++;
        close_out();
    end
endmodule // tb_top

bind can_transceiver_protection can_prot_chk chk_u (.CLK, .RST_N, .TXD_INT, .RXD_INT, .TEST_MODE, .SECOND_OUTPUT_PIN,
    .BUS_RX_DOMINANT, .BUS_DRIVE_DOMINANT, .BUS_BIAS_RECESSIVE, .DOMINANT_TIMEOUT, .THERMAL_FAULT, .IO_UNDERVOLTAGE,
    .MODE_REQ, .DEVICE_MODE, .THERMAL_STAT);

`default_nettype wire
